// File: vram_pen_pkg.sv
// Purpose: shared constants for the plane write control and pen capture block
// Assumes: eight bit i/o port bus, 20-bit cpu memory address
// Notes:   all port offsets, bit positions and reset values live here
package vram_pen_pkg;
  // i/o port decode
  localparam logic [7:0] PORT_VIDEO_CTRL  = 8'hD8;
  localparam logic [7:0] PORT_ADAPTER_A   = 8'hD9;
  localparam logic [7:0] PORT_ADDR_LATCH  = 8'hDA;
  localparam logic [7:0] PORT_ADAPTER_B   = 8'hDB;
  localparam logic [7:0] PORT_TC_INDEX    = 8'hDC;
  localparam logic [7:0] PORT_TC_DATA     = 8'hDD;
  // video control port fields, all active low
  localparam int VC_MASTER_BIT = 7;
  localparam int VC_LINK_LSB   = 4;  // link bit of plane p sits at 4 + p
  localparam int VC_FLASH_BIT  = 3;
  localparam int VC_SHOW_LSB   = 0;  // display enable of plane p sits at p
  // plane numbering: red 0, green 1, blue 2
  localparam int NUM_PLANES = 3;
  localparam logic [3:0] SEG_RED   = 4'hD;
  localparam logic [3:0] SEG_GREEN = 4'hE;
  localparam logic [3:0] SEG_BLUE  = 4'hC;
  // adapter port a and control b fields
  localparam int PA_SWITCH_BIT = 6;
  localparam int PA_CLEAR_BIT  = 7;
  localparam int CB_CLEAR_BIT  = 3;  // clear-screen, active high
  localparam int CB_FILL_BIT   = 2;  // fill level while clearing
  // reset values
  localparam logic [7:0] VIDEO_CTRL_RESET = 8'hFF;
  localparam logic [7:0] ADAPTER_RESET    = 8'h00;
  // timing controller register file
  localparam int         TC_NUM_REGS  = 18;
  localparam int         TC_IDX_W     = 5;
  localparam logic [4:0] TC_PEN_HIGH  = 5'h10;
  localparam logic [4:0] TC_PEN_LOW   = 5'h11;
  localparam int         MA_W         = 14;
  // pen position register layout and clear-screen fill bytes
  localparam int PEN_ROW_LSB = 4;
  localparam logic [7:0] FILL_ONES  = 8'hFF;
  localparam logic [7:0] FILL_ZEROS = 8'h00;
endpackage

// File: pen_link_if.sv
// Purpose: carries the pen capture signals between the top and the capture unit
// Assumes: single clock domain ref_clk
// Notes:   pulses last one cycle, levels are registered
`timescale 1ns/1ps
interface pen_link_if;
  logic arm;           // capture enable from the clear bit, high = armed
  logic switch_state;  // synchronised pen switch level
  logic hit_strobe;    // pen hit strobe, level until disarmed
  logic ctrl_strobe;   // strobe toward the controller, level
  logic ctrl_rise;     // one-cycle pulse on ctrl_strobe rising
  logic delayed_rise;  // one-cycle pulse of the delayed pen strobe
  modport capture (input arm, output switch_state, hit_strobe, ctrl_strobe, ctrl_rise,
                   delayed_rise);
  modport host (output arm, input switch_state, hit_strobe, ctrl_strobe, ctrl_rise,
                delayed_rise);
endinterface

// File: tc_reg_mem.sv
// Purpose: small register memory behind the timing controller data port
// Assumes: one write port and one read port on ref_clk
// Notes:   read data come from a register one cycle after the address
`timescale 1ns/1ps
module tc_reg_mem #(
  parameter int DEPTH = vram_pen_pkg::TC_NUM_REGS,
  parameter int AW    = vram_pen_pkg::TC_IDX_W,
  parameter int DW    = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          reset,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);
  logic [DW-1:0] mem_q [DEPTH];  // storage, no reset so it maps to ram

  // write port; addresses past the depth are dropped
  always_ff @(posedge ref_clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem_q[waddr] <= wdata;
    end
  end

  // registered read; out of range reads as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (int'(raddr) < DEPTH) begin
      rdata_q <= mem_q[raddr];
    end else begin
      rdata_q <= '0;
    end
  end
endmodule

// File: pen_capture.sv
// Purpose: light pen pulse conditioning, capture and strobe synchronisation
// Assumes: pen pins are asynchronous and pass two flip-flops first
// Notes:   capture flag is a set-only flop, held clear while disarmed
`timescale 1ns/1ps
module pen_capture (
  input  wire logic   ref_clk,
  input  wire logic   reset,
  input  wire logic   pen_pulse,
  input  wire logic   pen_invert,
  input  wire logic   pen_switch,
  pen_link_if.capture lk
);
  logic [1:0] pulse_sync_q;   // pen pulse synchroniser
  logic [1:0] inv_sync_q;     // polarity jumper synchroniser
  logic [1:0] sw_sync_q;      // pen switch synchroniser
  logic       cond_prev_q;    // conditioned pulse, one cycle back
  logic       cond_now;       // conditioned pulse, positive-going
  logic       hit_q;          // capture flag
  logic [1:0] video_sync_q;   // flag to controller strobe
  logic       delayed_q;      // third stage, one past the controller strobe, toward the pixel-side strobe
  logic       delayed_prev_q; // edge detect of delayed strobe

  // pin synchronisers; only the second stage is read by logic
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pulse_sync_q <= 2'h0;
      inv_sync_q   <= 2'h0;
      sw_sync_q    <= 2'h0;
    end else begin
      pulse_sync_q <= {pulse_sync_q[0], pen_pulse};
      inv_sync_q   <= {inv_sync_q[0], pen_invert};
      sw_sync_q    <= {sw_sync_q[0], pen_switch};
    end
  end

  // jumper picks the polarity so a rising edge always means a hit
  assign cond_now = pulse_sync_q[1] ^ inv_sync_q[1];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cond_prev_q <= 1'b0;
    end else begin
      cond_prev_q <= cond_now;
    end
  end

  // capture flag: data tied high, clocked by the pen edge, cleared while disarmed
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hit_q <= 1'b0;
    end else if (!lk.arm) begin
      hit_q <= 1'b0;
    end else if (cond_now && !cond_prev_q) begin
      hit_q <= 1'b1;  // once set further edges change nothing
    end
  end

  // two stages toward the controller strobe, one more for the delayed strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      video_sync_q   <= 2'h0;
      delayed_q      <= 1'b0;
      delayed_prev_q <= 1'b0;
    end else begin
      video_sync_q   <= {video_sync_q[0], hit_q};
      delayed_q      <= video_sync_q[1];
      delayed_prev_q <= delayed_q;
    end
  end

  assign lk.switch_state = sw_sync_q[1];
  assign lk.hit_strobe   = hit_q;
  assign lk.ctrl_strobe  = video_sync_q[1];
  assign lk.ctrl_rise    = video_sync_q[1] && !delayed_q;
  assign lk.delayed_rise = delayed_q && !delayed_prev_q;
endmodule

// File: vram_plane_write_and_pen_capture.sv
// Purpose: cpu access control for three video planes, clear-screen, pen capture
// Assumes: cpu drives one-cycle io and memory strobes on ref_clk
// Notes:   io and memory read data appear one cycle after the strobe
`timescale 1ns/1ps
module vram_plane_write_and_pen_capture (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  // cpu i/o port access
  input  wire logic [7:0]                   io_addr,
  input  wire logic [7:0]                   io_wdata,
  input  wire logic                         io_wr,
  input  wire logic                         io_rd,
  output logic      [7:0]                   io_rdata,
  // cpu memory access
  input  wire logic [19:0]                  mem_addr,
  input  wire logic [7:0]                   mem_wdata,
  input  wire logic                         mem_wr,
  input  wire logic                         mem_rd,
  output logic      [7:0]                   mem_rdata,
  output logic                              phantom,
  // video plane memories
  output logic      [15:0]                  plane_addr,
  output logic      [7:0]                   plane_wdata,
  output logic      [2:0]                   plane_we,
  input  wire logic [2:0][7:0]              plane_rdata,
  // display side
  input  wire logic [13:0]                  refresh_memory_address,
  input  wire logic [3:0]                   row_scan_address,
  input  wire logic [2:0]                   pixel_position_count,
  input  wire logic [2:0]                   pixel_in,
  output logic      [2:0]                   rgb_out,
  output logic                              controller_pen_strobe_input,
  // light pen pins and jumper
  input  wire logic                         pen_pulse,
  input  wire logic                         pen_switch,
  input  wire logic                         pen_invert,
  output logic      [7:0]                   pen_position
);
  localparam int NP = vram_pen_pkg::NUM_PLANES;

  logic [7:0]          video_ctrl_q;    // video control port, active low bits
  logic [7:0]          port_a_q;        // adapter port a written bits
  logic [7:0]          addr_latch_q;    // adapter address latch
  logic [7:0]          port_b_q;        // adapter control b
  logic [7:0]          tc_index_q;      // timing controller index
  logic [vram_pen_pkg::MA_W-1:0] pen_addr_q;  // latched refresh address
  logic [7:0]          pen_pos_q;       // scan line and pixel position
  logic [7:0]          io_rdata_q;      // io read data register
  logic [7:0]          mem_rdata_q;     // memory read data register
  logic [2:0]          rgb_q;           // colour output register
  logic [7:0]          tc_rdata;        // register memory read data
  logic                tc_we;           // register memory write strobe
  logic                clearing;        // clear-screen active
  logic                cpu_enabled;     // master enable decoded
  logic [NP-1:0]       target;          // one-hot addressed plane
  logic                plane_hit;       // address falls in a plane segment
  logic [NP-1:0]       write_mask;      // planes written by a cpu write
  logic [1:0]          rd_sel;          // plane index for reads

  pen_link_if lk ();

  pen_capture u_pen (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .pen_pulse  (pen_pulse),
    .pen_invert (pen_invert),
    .pen_switch (pen_switch),
    .lk         (lk.capture)
  );

  // the clear bit of port a arms the capture flag
  assign lk.arm = port_a_q[vram_pen_pkg::PA_CLEAR_BIT];

  tc_reg_mem #(
    .DEPTH (vram_pen_pkg::TC_NUM_REGS),
    .AW    (vram_pen_pkg::TC_IDX_W),
    .DW    (8)
  ) u_tc_mem (
    .ref_clk (ref_clk),
    .reset   (reset),
    .we      (tc_we),
    .waddr   (tc_index_q[vram_pen_pkg::TC_IDX_W-1:0]),
    .wdata   (io_wdata),
    .raddr   (tc_index_q[vram_pen_pkg::TC_IDX_W-1:0]),
    .rdata_q (tc_rdata)
  );

  // pen address registers are read only, so cpu writes to them are dropped
  assign tc_we = io_wr && (io_addr == vram_pen_pkg::PORT_TC_DATA)
                 && (tc_index_q[vram_pen_pkg::TC_IDX_W-1:0] != vram_pen_pkg::TC_PEN_HIGH)
                 && (tc_index_q[vram_pen_pkg::TC_IDX_W-1:0] != vram_pen_pkg::TC_PEN_LOW);

  // io port writes, one register per decoded port
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      video_ctrl_q <= vram_pen_pkg::VIDEO_CTRL_RESET;
      port_a_q     <= vram_pen_pkg::ADAPTER_RESET;
      addr_latch_q <= vram_pen_pkg::ADAPTER_RESET;
      port_b_q     <= vram_pen_pkg::ADAPTER_RESET;
      tc_index_q   <= vram_pen_pkg::ADAPTER_RESET;
    end else if (io_wr) begin
      if (io_addr == vram_pen_pkg::PORT_VIDEO_CTRL) begin
        video_ctrl_q <= io_wdata;
      end else if (io_addr == vram_pen_pkg::PORT_ADAPTER_A) begin
        port_a_q <= io_wdata;
      end else if (io_addr == vram_pen_pkg::PORT_ADDR_LATCH) begin
        addr_latch_q <= io_wdata;
      end else if (io_addr == vram_pen_pkg::PORT_ADAPTER_B) begin
        port_b_q <= io_wdata;
      end else if (io_addr == vram_pen_pkg::PORT_TC_INDEX) begin
        tc_index_q <= io_wdata;
      end
    end
  end

  // io reads are registered; unmapped ports read as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      io_rdata_q <= 8'h00;
    end else if (io_rd) begin
      if (io_addr == vram_pen_pkg::PORT_VIDEO_CTRL) begin
        io_rdata_q <= video_ctrl_q;
      end else if (io_addr == vram_pen_pkg::PORT_ADAPTER_A) begin
        // switch level replaces the stored bit six
        io_rdata_q <= {port_a_q[7], lk.switch_state, port_a_q[5:0]};
      end else if (io_addr == vram_pen_pkg::PORT_ADDR_LATCH) begin
        // the pen position register answers reads of this port
        io_rdata_q <= pen_pos_q;
      end else if (io_addr == vram_pen_pkg::PORT_ADAPTER_B) begin
        io_rdata_q <= port_b_q;
      end else if (io_addr == vram_pen_pkg::PORT_TC_INDEX) begin
        io_rdata_q <= tc_index_q;
      end else if (io_addr == vram_pen_pkg::PORT_TC_DATA) begin
        if (tc_index_q[vram_pen_pkg::TC_IDX_W-1:0] == vram_pen_pkg::TC_PEN_HIGH) begin
          io_rdata_q <= {2'h0, pen_addr_q[13:8]};
        end else if (tc_index_q[vram_pen_pkg::TC_IDX_W-1:0] == vram_pen_pkg::TC_PEN_LOW) begin
          io_rdata_q <= pen_addr_q[7:0];
        end else begin
          io_rdata_q <= tc_rdata;
        end
      end else begin
        io_rdata_q <= 8'h00;
      end
    end
  end

  // controller side: refresh address latched on the synchronised strobe edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pen_addr_q <= '0;
    end else if (lk.ctrl_rise) begin
      pen_addr_q <= refresh_memory_address;
    end
  end

  // pen position: held between delayed strobes, reads never disturb it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pen_pos_q <= 8'h00;
    end else if (lk.delayed_rise) begin
      pen_pos_q[7:vram_pen_pkg::PEN_ROW_LSB] <= row_scan_address;
      pen_pos_q[3]                           <= 1'b0;
      pen_pos_q[2:0]                         <= pixel_position_count;
    end
  end

  // decode of the cpu memory address into one plane
  always_comb begin
    target    = '0;
    rd_sel    = 2'd0;
    plane_hit = 1'b1;
    if (mem_addr[19:16] == vram_pen_pkg::SEG_RED) begin
      target = 3'b001;
      rd_sel = 2'd0;
    end else if (mem_addr[19:16] == vram_pen_pkg::SEG_GREEN) begin
      target = 3'b010;
      rd_sel = 2'd1;
    end else if (mem_addr[19:16] == vram_pen_pkg::SEG_BLUE) begin
      target = 3'b100;
      rd_sel = 2'd2;
    end else begin
      plane_hit = 1'b0;
    end
  end

  assign clearing    = port_b_q[vram_pen_pkg::CB_CLEAR_BIT];
  // clear-screen takes the planes away from the cpu whatever the master bit says
  assign cpu_enabled = !video_ctrl_q[vram_pen_pkg::VC_MASTER_BIT] && !clearing;

  // a zero link bit pulls that plane into every cpu write; links never touch reads
  generate
    for (genvar p = 0; p < NP; p++) begin : g_link
      assign write_mask[p] = target[p]
                             || !video_ctrl_q[vram_pen_pkg::VC_LINK_LSB + p];
    end
  endgenerate

  // plane port: clear-screen owns it, otherwise an enabled cpu write
  always_comb begin
    if (clearing) begin
      // displayed byte address: character address times sixteen plus scan line
      plane_addr  = {refresh_memory_address[11:0], row_scan_address};
      plane_wdata = port_b_q[vram_pen_pkg::CB_FILL_BIT] ? vram_pen_pkg::FILL_ONES
                                                         : vram_pen_pkg::FILL_ZEROS;
      plane_we    = 3'b111;
    end else begin
      plane_addr  = mem_addr[15:0];
      plane_wdata = mem_wdata;
      plane_we    = (mem_wr && plane_hit && cpu_enabled) ? write_mask : 3'b000;
    end
  end

  // phantom marks any enabled access to a plane
  assign phantom = cpu_enabled && plane_hit && (mem_wr || mem_rd);

  // reads return the single addressed plane only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_rdata_q <= 8'h00;
    end else if (mem_rd && plane_hit && cpu_enabled) begin
      mem_rdata_q <= plane_rdata[rd_sel];
    end
  end

  // display colour: never gated by the master bit, so refresh continues
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rgb_q <= 3'b000;
    end else if (clearing) begin
      rgb_q <= {NP{port_b_q[vram_pen_pkg::CB_FILL_BIT]}};
    end else if (!video_ctrl_q[vram_pen_pkg::VC_FLASH_BIT]) begin
      // flash forces the enabled colours regardless of memory contents
      rgb_q <= ~video_ctrl_q[2:0];
    end else begin
      rgb_q <= pixel_in & ~video_ctrl_q[2:0];
    end
  end

  assign io_rdata                    = io_rdata_q;
  assign mem_rdata                   = mem_rdata_q;
  assign rgb_out                     = rgb_q;
  assign controller_pen_strobe_input = lk.ctrl_strobe;
  assign pen_position                = pen_pos_q;
endmodule

// File: vram_pen_sva.sv
// Purpose: port-level checks for plane write control and pen capture
// Assumes: shadows of ports d8, d9 and db follow the cpu writes
// Notes:   one clock domain, so default clocking and disable are used
`timescale 1ns/1ps
module vram_pen_sva (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic [7:0]  io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic [19:0] mem_addr,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic        phantom,
  input wire logic [2:0]  plane_we,
  input wire logic [7:0]  plane_wdata,
  input wire logic        controller_pen_strobe_input,
  input wire logic [7:0]  pen_position
);
  logic [7:0] ctl_q, cb_q, pa_q;  // shadows of ports d8, db, d9
  logic [3:0] off_q;              // cycles spent disarmed, saturating
  logic [3:0] rise_q;             // cycles since the strobe rose
  logic [2:0] tgt;                // one-hot plane under the cpu address
  logic       clr, on;
  default clocking clk_cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  assign tgt = mem_addr[19:16] == 4'hD ? 3'h1 : mem_addr[19:16] == 4'hE ? 3'h2 :
               mem_addr[19:16] == 4'hC ? 3'h4 : 3'h0;
  assign clr = cb_q[3];
  assign on  = !ctl_q[7] && !clr && tgt != 3'h0;
  // port shadows follow writes at the taking edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_q <= 8'hFF;
      cb_q  <= 8'h00;
      pa_q  <= 8'h00;
    end else if (io_wr) begin
      if (io_addr == 8'hD8) ctl_q <= io_wdata;
      if (io_addr == 8'hDB) cb_q <= io_wdata;
      if (io_addr == 8'hD9) pa_q <= io_wdata;
    end
  end
  // counters give the pen rules a bounded window
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      off_q  <= 4'h0;
      rise_q <= 4'hF;
    end else begin
      off_q  <= pa_q[7] ? 4'h0 : (off_q == 4'hF ? off_q : off_q + 4'h1);
      rise_q <= $rose(controller_pen_strobe_input) ? 4'h0 :
                (rise_q == 4'hF ? rise_q : rise_q + 4'h1);
    end
  end
  sequence rd_unmapped;
    io_rd && (io_addr < 8'hD8 || io_addr > 8'hDD);
  endsequence
  sequence armed_high;
    controller_pen_strobe_input && pa_q[7];
  endsequence
  disengage_block_a: assert property (mem_wr && ctl_q[7] && !clr |->
    plane_we == 3'h0 && !phantom) else $error("write reached a plane while disengaged");
  phantom_on_a: assert property ((mem_wr || mem_rd) && on |-> phantom)
    else $error("phantom low on an enabled plane access");
  write_mask_a: assert property (mem_wr && on |-> plane_we == (tgt | ~ctl_q[6:4]))
    else $error("plane write mask wrong");
  read_no_write_a: assert property (mem_rd && !mem_wr && !clr |-> plane_we == 3'h0)
    else $error("read raised a plane write");
  clear_fill_a: assert property (clr |-> plane_we == 3'h7 && plane_wdata == {8{cb_q[2]}})
    else $error("clear-screen fill wrong");
  clear_block_a: assert property (clr |-> !phantom)
    else $error("cpu reached memory while clearing");
  disarm_hold_a: assert property (off_q > 4'h5 |-> !controller_pen_strobe_input)
    else $error("pen strobe high while disarmed");
  strobe_stay_a: assert property (armed_high |=> controller_pen_strobe_input)
    else $error("pen strobe dropped while armed");
  pen_hold_a: assert property ($changed(pen_position) |-> rise_q < 4'h4)
    else $error("pen register changed without a strobe");
  unmapped_read_a: assert property (rd_unmapped |=> io_rdata == 8'h00)
    else $error("unmapped port read not zero");
endmodule

// File: plane_mem_model.sv
// Purpose: three video plane memories on the block's plane port
// Assumes: write on the clock edge, read straight off the address
// Notes:   bytes start at a pattern so a missed write shows up
`timescale 1ns/1ps
module plane_mem_model (
  input  wire logic            ref_clk,
  input  wire logic [15:0]     plane_addr,
  input  wire logic [7:0]      plane_wdata,
  input  wire logic [2:0]      plane_we,
  output logic      [2:0][7:0] plane_rdata
);
  logic [7:0] mem [3][65536];  // red, green, blue
  initial begin
    for (int a = 0; a < 65536; a++) begin
      for (int p = 0; p < 3; p++) mem[p][a] = 8'hA5 ^ a[7:0] ^ 8'(p);
    end
  end
  // each plane writes only under its own enable
  always @(posedge ref_clk) begin
    for (int p = 0; p < 3; p++) if (plane_we[p]) mem[p][plane_addr] <= plane_wdata;
  end
  // reads of all planes share one address
  always_comb begin
    for (int p = 0; p < 3; p++) plane_rdata[p] = mem[p][plane_addr];
  end
endmodule

// File: vram_plane_write_and_pen_capture_bench.sv
// Purpose: self-checking bench for plane write control and pen capture
// Assumes: cpu strobes last one cycle and change on the falling edge
// Notes:   the pen strobe rise is waited on under a bound, other pen steps wait fixed counts
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module vram_plane_write_and_pen_capture_bench;
  logic            ref_clk, reset, io_wr, io_rd, mem_wr, mem_rd, phantom;
  logic            pen_pulse, pen_switch, pen_invert, controller_pen_strobe_input;
  logic [7:0]      io_addr, io_wdata, io_rdata, mem_wdata, mem_rdata, plane_wdata;
  logic [7:0]      pen_position, d, v, e;
  logic [19:0]     mem_addr;
  logic [15:0]     plane_addr, off;
  logic [2:0]      plane_we, pixel_in, rgb_out, pix, lk;
  logic [2:0][7:0] plane_rdata;
  logic [13:0]     rma;
  logic [3:0]      row;
  logic [7:0]      old [3];
  logic [3:0]      segs [3] = '{4'hD, 4'hE, 4'hC};  // red, green, blue
  logic [7:0]      bad [4] = '{8'hD7, 8'hDE, 8'h00, 8'hFF};
  int              err_count, checked, cycles, t;
  logic [31:0]     seed = 32'h959a;
  vram_plane_write_and_pen_capture i_dut (.ref_clk, .reset, .io_addr, .io_wdata, .io_wr,
    .io_rd, .io_rdata, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata, .phantom,
    .plane_addr, .plane_wdata, .plane_we, .plane_rdata, .refresh_memory_address(rma),
    .row_scan_address(row), .pixel_position_count(pix), .pixel_in, .rgb_out,
    .controller_pen_strobe_input, .pen_pulse, .pen_switch, .pen_invert, .pen_position);
  plane_mem_model i_mem (.ref_clk, .plane_addr, .plane_wdata, .plane_we, .plane_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // addressed plane or a plane whose link bit is low takes the data
  function automatic logic [7:0] want(int p, int t, logic [2:0] l, logic [7:0] v, logic [7:0] o);
    return (p == t || !l[p]) ? v : o;
  endfunction
  // tasks end with an idle cycle so strobes never toggle twice in a step
  task automatic io_w(input logic [7:0] a, input logic [7:0] x);
    io_addr = a;
    io_wdata = x;
    io_wr = 1'b1;
    @(negedge ref_clk) io_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic io_r(input logic [7:0] a, output logic [7:0] x);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge ref_clk) io_rd = 1'b0;
    x = io_rdata;
    @(negedge ref_clk);
  endtask
  task automatic mem_t(input logic w, input logic [19:0] a, input logic [7:0] x, input logic ph);
    mem_addr = a;
    mem_wdata = x;
    mem_wr = w;
    mem_rd = !w;
    #1 `CHK(phantom, ph)
    @(negedge ref_clk) {mem_wr, mem_rd} = 2'b00;
    @(negedge ref_clk);
  endtask
  task automatic pulse();
    pen_pulse = ~pen_invert;
    repeat (4) @(negedge ref_clk);
    pen_pulse = pen_invert;
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      report_and_stop();
    end
  end
  initial begin
    {io_wr, io_rd, mem_wr, mem_rd, pen_pulse, pen_switch, pen_invert} = '0;
    {io_addr, io_wdata, mem_addr, mem_wdata, pixel_in, pix, row} = '0;
    rma = 14'h01ED;
    reset = 1'b1;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    io_r(8'hD8, d); `CHK(d, vram_pen_pkg::VIDEO_CTRL_RESET)
    io_r(8'hDB, d); `CHK(d, vram_pen_pkg::ADAPTER_RESET)
    for (int k = 0; k < 4; k++) begin
      io_r(bad[k], d); `CHK(d, 8'h00)
    end
    for (int s = 0; s < 2; s++) begin
      pen_switch = s[0];
      repeat (3) @(negedge ref_clk);
      io_r(8'hD9, d); `CHK(d[6], s[0])
    end
    $display("test ports done");
    // disengaged: display still runs, cpu reaches nothing
    io_w(8'hF8, 8'hF8);
    io_w(8'hD8, 8'hF8);
    pixel_in = 3'h5;
    repeat (3) @(negedge ref_clk);
    `CHK(rgb_out, 3'h5)
    // flash with only red disabled forces cyan while still disengaged
    io_w(8'hD8, 8'hF1);
    `CHK(rgb_out, 3'h6)
    old[0] = i_mem.mem[0][16'h0010];
    mem_t(1'b1, 20'hD0010, 8'h3C, 1'b0);
    `CHK(i_mem.mem[0][16'h0010], old[0])
    mem_t(1'b0, 20'hD0010, 8'h00, 1'b0); `CHK(mem_rdata, 8'h00)
    $display("test disengage done");
    for (int k = 0; k < 24; k++) begin
      lk = 3'(k % 8);
      t = k / 8;
      off = rnd();
      v = rnd();
      io_w(8'hD8, {1'b0, lk, 4'h8});
      for (int p = 0; p < 3; p++) old[p] = i_mem.mem[p][off];
      mem_t(1'b1, {segs[t], off}, v, 1'b1);
      for (int p = 0; p < 3; p++) `CHK(i_mem.mem[p][off], want(p, t, lk, v, old[p]))
      mem_t(1'b0, {segs[(t + 1) % 3], off}, 8'h00, 1'b1);
      `CHK(mem_rdata, i_mem.mem[(t + 1) % 3][off])
    end
    $display("test links done");
    for (int f = 0; f < 2; f++) begin
      io_w(8'hDB, {4'h0, 1'b1, f[0], 2'b00});
      rma = rnd();
      row = rnd();
      @(negedge ref_clk);
      `CHK(plane_we, 3'h7)
      `CHK(plane_wdata, {8{f[0]}})
      `CHK(plane_addr, {rma[11:0], row})
      mem_t(1'b1, 20'hE0000, 8'h11, 1'b0);
    end
    io_w(8'hDB, 8'h00);
    $display("test clear done");
    for (int i = 0; i < 2; i++) begin
      pen_invert = i[0];
      pen_pulse = i[0];
      repeat (4) @(negedge ref_clk);
      pulse();
      `CHK(controller_pen_strobe_input, 1'b0)
      io_w(8'hD9, 8'h80);
      rma = rnd();
      row = rnd();
      pix = rnd();
      e = {row, 1'b0, pix};
      pulse();
      for (int n = 0; n < 30 && controller_pen_strobe_input !== 1'b1; n++) @(negedge ref_clk);
      `CHK(controller_pen_strobe_input, 1'b1)
      io_r(8'hDA, d); `CHK(d, e)
      io_w(8'hDC, 8'h10);
      io_r(8'hDD, d); `CHK(d, {2'b00, rma[13:8]})
      v = d;
      io_w(8'hDC, 8'h11);
      io_r(8'hDD, d); `CHK(d, rma[7:0])
      // software side: start address 0x0140, delay correction of three characters
      off = {v, d} - 16'h0140 - 16'h0003;
      io_w(8'hDC, 8'h0D);
      io_w(8'hDD, 8'h40);
      io_r(8'hDD, d); `CHK(d, 8'h40)
      `CHK(off % 16'd80, 16'((16'(rma) - 16'h0143) % 16'd80))
      row = ~row;
      pix = ~pix;
      pulse();
      `CHK(pen_position, e)
      io_w(8'hD9, 8'h00);
      repeat (6) @(negedge ref_clk);
      `CHK(controller_pen_strobe_input, 1'b0)
    end
    $display("test pen done");
    report_and_stop();
  end
endmodule
bind vram_plane_write_and_pen_capture vram_pen_sva i_sva (.ref_clk, .reset, .io_addr,
  .io_wdata, .io_wr, .io_rd, .io_rdata, .mem_addr, .mem_wr, .mem_rd, .phantom, .plane_we,
  .plane_wdata, .controller_pen_strobe_input, .pen_position);
